//--- rtl/bridge_flag_core.sv
// Status, error and command flag logic of the bridge, with an AXI4-Lite register slave.
module bridge_flag_core #(
	parameter int GROUPS = 5
) (
	input  wire logic                          core_clk,
	input  wire logic                          rst,
	input  wire logic [flag_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [flag_pkg::DATA_W-1:0]   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [flag_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [flag_pkg::DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic                          short_det,
	input  wire logic                          supply_low_det,
	input  wire logic                          line_break_det,
	input  wire logic                          slave_drop_det,
	input  wire logic                          slave_status_fault,
	input  wire logic                          slave_addr_fault,
	input  wire logic [7:0]                    fault_slave_addr,
	input  wire logic                          fault_slave_is_input,
	input  wire logic                          hw_fault,
	input  wire logic                          net_xfer_err,
	input  wire logic                          selftest_done,
	input  wire logic                          param_done_evt,
	input  wire logic                          param_fault_evt,
	input  wire logic                          detect_done_evt,
	input  wire logic                          err_code_valid,
	input  wire logic [flag_pkg::WORD_W-1:0]   err_code_in,
	output logic                               addr_detect_start,
	output logic                               param_xfer_start,
	output logic [GROUPS-1:0]                  err_summary,
	output logic [GROUPS-1:0]                  remote_ready
);
	import flag_pkg::*;

	logic                aw_got_ff, w_got_ff, awready_ff, wready_ff, bvalid_ff;
	logic                arready_ff, rvalid_ff;
	logic [1:0]          bresp_ff, rresp_ff;
	logic [DATA_W-1:0]   rdata_ff, wdata_ff, rd_mux;
	logic [ADDR_W-1:0]   waddr_ff;
	logic [3:0]          wstrb_ff;
	logic                rd_err, wr_do, aw_hs, w_hs, ar_hs;
	logic                detect_cmd_ff, detect_cmd_d_ff, xfer_req_ff, xfer_req_d_ff;
	logic [GROUPS-1:0]   clr_req_ff, clr_req_d_ff, occ_mask, clr_fall_vec;
	logic [OCC_W-1:0]    occ_ff, occ_eff;
	logic                detect_fall, xfer_rise, clr_any, clr_top;
	logic                cable_short_ff, supply_drop_ff, line_break_ff, alarm_ff;
	logic                param_done_ff, param_err_ff, busy_ff;
	logic                brk_cause, alm_cause, summary_cause, brk_new, alm_new, id_load;
	logic [ID_W-1:0]     latest_fault_slave_id, nxt_fault_id;
	logic [WORD_W-1:0]   latest_err_code_word, latest_err_id_word;
	logic [WORD_W-1:0]   err_id_count_word, alarm_id_count_word;
	logic                detect_start_ff, xfer_start_ff;
	logic [GROUPS-1:0]   summary_ff, ready_ff;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign aw_hs = s_axi_awvalid & awready_ff;
	assign w_hs  = s_axi_wvalid & wready_ff;
	assign ar_hs = s_axi_arvalid & arready_ff;
	assign wr_do = aw_got_ff & w_got_ff & ~bvalid_ff;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			awready_ff <= 1'b1;
			aw_got_ff  <= 1'b0;
			waddr_ff   <= '0;
		end else if (aw_hs) begin
			awready_ff <= 1'b0;
			aw_got_ff  <= 1'b1;
			waddr_ff   <= s_axi_awaddr;
		end else begin
			if (wr_do)
				aw_got_ff <= 1'b0;
			if (bvalid_ff & s_axi_bready)
				awready_ff <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wready_ff <= 1'b1;
			w_got_ff  <= 1'b0;
			wdata_ff  <= '0;
			wstrb_ff  <= '0;
		end else if (w_hs) begin
			wready_ff <= 1'b0;
			w_got_ff  <= 1'b1;
			wdata_ff  <= s_axi_wdata;
			wstrb_ff  <= s_axi_wstrb;
		end else begin
			if (wr_do)
				w_got_ff <= 1'b0;
			if (bvalid_ff & s_axi_bready)
				wready_ff <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (wr_do) begin
			bvalid_ff <= 1'b1;
			// read-only words accept writes silently; only holes answer with an error
			case (waddr_ff[ADDR_W-1:2])
				STATUS_OFS[7:2], CTRL_OFS[7:2], ERR_CODE_OFS[7:2], ERR_ID_OFS[7:2], COUNT_OFS[7:2]:
					bresp_ff <= RESP_OKAY;
				default:
					bresp_ff <= RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_comb begin
		rd_mux = '0;
		rd_err = 1'b0;
		case (s_axi_araddr[ADDR_W-1:2])
			STATUS_OFS[7:2]: begin
				rd_mux[ST_SHORT]                 = cable_short_ff;
				rd_mux[ST_DROP]                  = supply_drop_ff;
				rd_mux[ST_BREAK]                 = line_break_ff;
				rd_mux[ST_ALARM]                 = alarm_ff;
				rd_mux[ST_PDONE]                 = param_done_ff;
				rd_mux[ST_PERR]                  = param_err_ff;
				rd_mux[ST_BUSY]                  = busy_ff;
				rd_mux[ST_SUMMARY]               = summary_ff[0];
				rd_mux[ST_READY]                 = ready_ff[0];
				rd_mux[ST_ID_LSB+:ID_W]          = latest_fault_slave_id;
			end
			CTRL_OFS[7:2]: begin
				rd_mux[CT_DETECT]                = detect_cmd_ff;
				rd_mux[CT_XFER]                  = xfer_req_ff;
				rd_mux[CT_CLR_LSB+:GROUPS]       = clr_req_ff;
				rd_mux[CT_OCC_LSB+:OCC_W]        = occ_ff;
			end
			ERR_CODE_OFS[7:2]: rd_mux[WORD_W-1:0] = latest_err_code_word;
			ERR_ID_OFS[7:2]:   rd_mux[WORD_W-1:0] = latest_err_id_word;
			COUNT_OFS[7:2]:    rd_mux            = {alarm_id_count_word, err_id_count_word};
			default:           rd_err            = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= '0;
			rresp_ff   <= RESP_OKAY;
		end else if (ar_hs) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rdata_ff   <= rd_mux;
			rresp_ff   <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (rvalid_ff & s_axi_rready) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	// ****************************************
	// command bits and their edges
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			detect_cmd_ff <= 1'b0;
			xfer_req_ff   <= 1'b0;
			clr_req_ff    <= '0;
			occ_ff        <= OCC_RST;
		end else if (wr_do && waddr_ff[ADDR_W-1:2] == CTRL_OFS[7:2]) begin
			if (wstrb_ff[0]) begin
				detect_cmd_ff <= wdata_ff[CT_DETECT];
				xfer_req_ff   <= wdata_ff[CT_XFER];
				clr_req_ff    <= wdata_ff[CT_CLR_LSB+:GROUPS];
			end
			if (wstrb_ff[1])
				occ_ff <= wdata_ff[CT_OCC_LSB+:OCC_W];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			detect_cmd_d_ff <= 1'b0;
			xfer_req_d_ff   <= 1'b0;
			clr_req_d_ff    <= '0;
		end else begin
			detect_cmd_d_ff <= detect_cmd_ff;
			xfer_req_d_ff   <= xfer_req_ff;
			clr_req_d_ff    <= clr_req_ff;
		end
	end

	// out-of-range group counts fall back to the nearest legal one
	assign occ_eff = (occ_ff == '0) ? OCC_W'(1) : (occ_ff > OCC_W'(GROUPS)) ? OCC_W'(GROUPS) : occ_ff;

	for (genvar g = 0; g < GROUPS; g++) begin : g_grp
		assign occ_mask[g] = (OCC_W'(g) < occ_eff);
	end

	assign detect_fall  = detect_cmd_d_ff & ~detect_cmd_ff;
	assign xfer_rise    = xfer_req_ff & ~xfer_req_d_ff;
	assign clr_fall_vec = clr_req_d_ff & ~clr_req_ff & occ_mask;
	assign clr_any      = |clr_fall_vec;
	assign clr_top      = clr_fall_vec[occ_eff-OCC_W'(1)];

	// ****************************************
	// sticky error flags; a new cause beats a clear
	// ****************************************
	assign brk_cause     = line_break_det | slave_drop_det;
	assign alm_cause     = slave_status_fault | slave_addr_fault;
	assign summary_cause = short_det | supply_low_det | brk_cause | hw_fault;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cable_short_ff <= 1'b0;
			supply_drop_ff <= 1'b0;
			line_break_ff  <= 1'b0;
			alarm_ff       <= 1'b0;
			param_err_ff   <= 1'b0;
		end else begin
			cable_short_ff <= short_det | (cable_short_ff & ~clr_any);
			supply_drop_ff <= supply_low_det | (supply_drop_ff & ~clr_any);
			line_break_ff  <= brk_cause | (line_break_ff & ~clr_any);
			alarm_ff       <= alm_cause | (alarm_ff & ~clr_any);
			param_err_ff   <= param_fault_evt | (param_err_ff & ~clr_top);
		end
	end

	for (genvar g = 0; g < GROUPS; g++) begin : g_out
		always_ff @(posedge core_clk) begin
			if (rst) begin
				summary_ff[g] <= 1'b0;
				ready_ff[g]   <= 1'b0;
			end else begin
				summary_ff[g] <= occ_mask[g] & (summary_cause | (summary_ff[g] & ~clr_any));
				// a fault holds ready low even while self test reports done
				if (hw_fault | net_xfer_err)
					ready_ff[g] <= 1'b0;
				else if (selftest_done)
					ready_ff[g] <= occ_mask[g];
				else if (!occ_mask[g])
					ready_ff[g] <= 1'b0;
			end
		end
	end

	assign err_summary  = summary_ff;
	assign remote_ready = ready_ff;

	// ****************************************
	// parameter transfer and address detection
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			param_done_ff <= 1'b0;
			xfer_start_ff <= 1'b0;
		end else begin
			param_done_ff <= param_done_evt | (param_done_ff & ~xfer_rise);
			xfer_start_ff <= xfer_rise;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			busy_ff         <= 1'b0;
			detect_start_ff <= 1'b0;
		end else begin
			busy_ff         <= detect_fall | (busy_ff & ~detect_done_evt);
			detect_start_ff <= detect_fall;
		end
	end

	assign addr_detect_start = detect_start_ff;
	assign param_xfer_start  = xfer_start_ff;

	// ****************************************
	// fault id and error words
	// ****************************************
	assign brk_new      = brk_cause & (~line_break_ff | clr_any);
	assign alm_new      = alm_cause & (~alarm_ff | clr_any);
	assign id_load      = brk_new | alm_new;
	assign nxt_fault_id = {fault_slave_is_input, 1'b0, fault_slave_addr};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			latest_fault_slave_id <= '0;
			latest_err_id_word    <= '0;
		end else if (id_load) begin
			latest_fault_slave_id <= nxt_fault_id;
			latest_err_id_word    <= WORD_W'(nxt_fault_id);
		end else if (clr_any) begin
			latest_fault_slave_id <= '0;
			latest_err_id_word    <= '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			latest_err_code_word <= '0;
		else if (err_code_valid)
			latest_err_code_word <= err_code_in;
		else if (clr_any)
			latest_err_code_word <= '0;
	end

	// counters saturate rather than wrap so a long fault storm never reads as few
	always_ff @(posedge core_clk) begin
		if (rst) begin
			err_id_count_word   <= '0;
			alarm_id_count_word <= '0;
		end else begin
			if (clr_any)
				err_id_count_word <= WORD_W'(brk_new);
			else if (brk_new && err_id_count_word != '1)
				err_id_count_word <= err_id_count_word + WORD_W'(1);
			if (clr_any)
				alarm_id_count_word <= WORD_W'(alm_new);
			else if (alm_new && alarm_id_count_word != '1)
				alarm_id_count_word <= alarm_id_count_word + WORD_W'(1);
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	sequence clr0_fall_s;
		(clr_req_ff[0] & occ_mask[0]) ##1 ~clr_req_ff[0];
	endsequence
	sequence quiet_s;
		~short_det & ~supply_low_det & ~brk_cause & ~alm_cause & ~hw_fault;
	endsequence

	drop_set_a:     assert property (supply_low_det |=> supply_drop_ff)
		else $error("supply drop flag not set");
	drop_hold_a:    assert property (supply_drop_ff & ~clr_any |=> supply_drop_ff)
		else $error("supply drop flag lost");
	break_set_a:    assert property (slave_drop_det |=> line_break_ff ##0 summary_ff[0])
		else $error("line break not flagged");
	break_hold_a:   assert property (line_break_ff & ~clr_any |=> line_break_ff)
		else $error("line break flag lost");
	id_load_a:      assert property (id_load |=> latest_fault_slave_id == $past(nxt_fault_id))
		else $error("fault id not loaded");
	id_range_a:     assert property (latest_fault_slave_id[ID_ZERO_BIT] == 1'b0)
		else $error("fault id outside encoded ranges");
	id_input_a:     assert property (id_load & fault_slave_is_input |=>
		latest_fault_slave_id[ID_INPUT_BIT])
		else $error("input slave id not in upper range");
	id_keep_a:      assert property (~brk_cause & ~alm_cause & ~clr_any |=> $stable(latest_fault_slave_id))
		else $error("fault id changed without cause");
	alarm_hold_a:   assert property (slave_addr_fault ##1 (~clr_any)[*3] |=> alarm_ff)
		else $error("alarm flag not held");
	pdone_set_a:    assert property (param_done_evt |=> param_done_ff)
		else $error("done flag not set");
	pdone_drop_a:   assert property (xfer_rise & ~param_done_evt |=> ~param_done_ff)
		else $error("done flag kept after request");
	perr_keep_a:    assert property (param_err_ff & ~clr_top |=> param_err_ff)
		else $error("parameter error lost");
	busy_span_a:    assert property (detect_fall |=> busy_ff until_with detect_done_evt)
		else $error("busy dropped early");
	busy_end_a:     assert property (detect_done_evt & ~detect_fall |=> ~busy_ff)
		else $error("busy outlived detection");
	sum_hold_a:     assert property (summary_ff[0] & ~clr_any |=> summary_ff[0])
		else $error("summary flag lost");
	ready_up_a:     assert property (selftest_done & ~hw_fault & ~net_xfer_err |=> ready_ff[0])
		else $error("ready not raised");
	ready_down_a:   assert property (hw_fault | net_xfer_err |=> ~ready_ff[0])
		else $error("ready kept through fault");
	clear_pulse_a:  assert property (clr0_fall_s ##0 quiet_s |=>
		~cable_short_ff & ~supply_drop_ff & ~line_break_ff & ~alarm_ff & latest_fault_slave_id == '0)
		else $error("clear pulse left a flag");
	reset_clear_a:  assert property (disable iff (1'b0) rst |=>
		~cable_short_ff & ~line_break_ff & ~param_err_ff & err_id_count_word == '0)
		else $error("reset left error state");
	short_hold_a:   assert property (cable_short_ff & ~clr_any |=> cable_short_ff)
		else $error("short flag lost");
	clr_level_a:    assert property ((clr_req_ff[0] & clr_req_d_ff[0])[*2] ##0 (cable_short_ff & ~clr_any)
		|=> cable_short_ff)
		else $error("held clear request cleared a flag");
endmodule

//--- rtl/flag_pkg.sv
// Shared constants for the bridge status and error flag block.
package flag_pkg;
	localparam int         ADDR_W       = 8;
	localparam int         DATA_W       = 32;
	localparam int         ID_W         = 10;
	localparam int         WORD_W       = 16;
	localparam int         OCC_W        = 3;
	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] STATUS_OFS   = 8'h00;
	localparam logic [7:0] CTRL_OFS     = 8'h04;
	localparam logic [7:0] ERR_CODE_OFS = 8'h08;
	localparam logic [7:0] ERR_ID_OFS   = 8'h0C;
	localparam logic [7:0] COUNT_OFS    = 8'h10;
	// ****************************************
	// status register fields
	// ****************************************
	localparam int         ST_SHORT     = 0;
	localparam int         ST_DROP      = 1;
	localparam int         ST_BREAK     = 2;
	localparam int         ST_ALARM     = 3;
	localparam int         ST_PDONE     = 4;
	localparam int         ST_PERR      = 5;
	localparam int         ST_BUSY      = 6;
	localparam int         ST_SUMMARY   = 7;
	localparam int         ST_READY     = 8;
	localparam int         ST_ID_LSB    = 16;
	// ****************************************
	// control register fields
	// ****************************************
	localparam int         CT_DETECT    = 0;
	localparam int         CT_XFER      = 1;
	localparam int         CT_CLR_LSB   = 2;
	localparam int         CT_OCC_LSB   = 8;
	localparam int         CT_W         = 11;
	// ****************************************
	// fault id encoding, reset values and response codes
	// ****************************************
	localparam int         ID_INPUT_BIT = 9;
	localparam int         ID_ZERO_BIT  = 8;
	localparam logic [2:0] OCC_RST      = 3'h1;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage

//--- test/bridge_error_status_flags_tb_top.sv
// Self-checking bench for the bridge status and error flag core.
module bridge_error_status_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import flag_pkg::*;
	logic core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, addr_detect_start, param_xfer_start;
	logic [7:0] s_axi_awaddr, s_axi_araddr, fault_slave_addr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] err_code_in;
	logic [4:0] err_summary, remote_ready;
	logic short_det, supply_low_det, line_break_det, slave_drop_det, slave_status_fault, slave_addr_fault;
	logic fault_slave_is_input, hw_fault, net_xfer_err, selftest_done, param_done_evt, param_fault_evt;
	logic detect_done_evt, err_code_valid;
	logic [5:0] cause;
	logic [2:0] ev;
	logic [9:0] id;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int error_cnt, n_tests, n_starts;
	localparam logic [8:0] MSK [6] = '{9'h081, 9'h082, 9'h084, 9'h084, 9'h008, 9'h008};
	assign {slave_addr_fault, slave_status_fault, slave_drop_det, line_break_det, supply_low_det, short_det} = cause;
	assign {detect_done_evt, param_fault_evt, param_done_evt} = ev;
	bridge_flag_core dut_u (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .short_det,
		.supply_low_det, .line_break_det, .slave_drop_det, .slave_status_fault, .slave_addr_fault,
		.fault_slave_addr, .fault_slave_is_input, .hw_fault, .net_xfer_err, .selftest_done, .param_done_evt,
		.param_fault_evt, .detect_done_evt, .err_code_valid, .err_code_in, .addr_detect_start,
		.param_xfer_start, .err_summary, .remote_ready);
	host_model host_u (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rready, .s_axi_rvalid);
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic chk_r(input logic [33:0] got, input logic [33:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic [1:0] got, input logic [1:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// ****************************************
	// result watcher
	// ****************************************
	always @(posedge core_clk) begin
		if (s_axi_rvalid & s_axi_rready) chk_r({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid & s_axi_bready) chk_b(s_axi_bresp, bq.pop_front());
		if (param_xfer_start === 1'b1 || addr_detect_start === 1'b1) n_starts++;
	end
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		bq.push_back(a > COUNT_OFS ? RESP_SLVERR : RESP_OKAY);
		host_u.wr(a, d);
	endtask
	task automatic r(input logic [7:0] a, input logic [31:0] e);
		rq.push_back({a > COUNT_OFS ? RESP_SLVERR : RESP_OKAY, e});
		host_u.rd(a);
	endtask
	task automatic pulse(input logic [5:0] c, input logic [2:0] e);
		@(posedge core_clk);
		cause <= c;
		ev <= e;
		err_code_valid <= |c;
		@(posedge core_clk);
		cause <= 6'h00;
		ev <= 3'h0;
		err_code_valid <= 1'b0;
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'hC751));
		{rst, cause, ev, fault_slave_addr, fault_slave_is_input, hw_fault, net_xfer_err} = {1'b1, 20'h0};
		{selftest_done, err_code_valid, err_code_in} = 18'h0;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		r(STATUS_OFS, 32'h0);
		r(CTRL_OFS, 32'h100);
		r(8'h14, 32'h0);
		w(8'h14, 32'h1);
		$display("test reset done");
		selftest_done <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			fault_slave_addr <= 8'($urandom);
			fault_slave_is_input <= 1'($urandom);
			err_code_in <= 16'($urandom);
			pulse(6'h01 << i, 3'h0);
			id = i > 1 ? {fault_slave_is_input, 1'b0, fault_slave_addr} : 10'h0;
			r(STATUS_OFS, {6'h00, id, 7'h00, 9'h100 | MSK[i]});
			r(ERR_ID_OFS, {22'h0, id});
			r(ERR_CODE_OFS, {16'h0000, err_code_in});
			r(COUNT_OFS, {15'h0000, 1'(i > 3), 15'h0000, 1'(i == 2 || i == 3)});
			w(CTRL_OFS, 32'h104);
			r(STATUS_OFS, {6'h00, id, 7'h00, 9'h100 | MSK[i]});
			w(CTRL_OFS, 32'h100);
			r(STATUS_OFS, 32'h100);
			r(COUNT_OFS, 32'h0);
		end
		$display("test sticky done");
		w(CTRL_OFS, 32'h500);
		pulse(6'h00, 3'h3);
		r(STATUS_OFS, 32'h130);
		chk_r({29'h0, remote_ready}, 34'h1F);
		w(CTRL_OFS, 32'h502);
		r(STATUS_OFS, 32'h120);
		w(CTRL_OFS, 32'h504);
		w(CTRL_OFS, 32'h500);
		r(STATUS_OFS, 32'h120);
		w(CTRL_OFS, 32'h540);
		w(CTRL_OFS, 32'h500);
		r(STATUS_OFS, 32'h100);
		w(CTRL_OFS, 32'h501);
		w(CTRL_OFS, 32'h500);
		r(STATUS_OFS, 32'h140);
		pulse(6'h00, 3'h4);
		r(STATUS_OFS, 32'h100);
		chk_r({2'h0, 32'(n_starts)}, 34'h2);
		$display("test param done");
		fault_slave_addr <= 8'($urandom);
		fault_slave_is_input <= 1'b0;
		pulse(6'h04, 3'h0);
		id = {2'h0, fault_slave_addr};
		fault_slave_addr <= ~fault_slave_addr;
		hw_fault <= 1'b1;
		pulse(6'h01, 3'h0);
		r(STATUS_OFS, {6'h00, id, 16'h0085});
		chk_r({29'h0, err_summary}, 34'h1F);
		chk_r({29'h0, remote_ready}, 34'h0);
		$display("test fault done");
		@(posedge core_clk);
		print_verdict();
	end
endmodule

//--- test/host_model.sv
// Host controller model: AXI4-Lite master that reaches the flag registers.
module host_model (
	input  wire logic        core_clk,
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	output logic             s_axi_bready,
	input  wire logic        s_axi_bvalid,
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	output logic             s_axi_rready,
	input  wire logic        s_axi_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awvalid & s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid & s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bready & s_axi_bvalid));
		s_axi_bready <= 1'b0;
		// released lines show garbage, not the last value
		s_axi_awaddr <= ~s_axi_awaddr;
		s_axi_wdata <= ~s_axi_wdata;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arvalid & s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rready & s_axi_rvalid));
		s_axi_rready <= 1'b0;
		s_axi_araddr <= ~s_axi_araddr;
	endtask
endmodule
